// ==== rtl/ftbs_pkg.sv ====
/*
  Shared constants, types and helper functions of the flow-through burst SRAM port.
  Assumes a single rising-edge clock and a synchronous controller on the far side.
*/
package ftbs_pkg;

  localparam int FTBS_WIDE_DATA_W = 36;
  localparam int FTBS_NARROW_DATA_W = 18;
  localparam int FTBS_WIDE_ADDR_W = 21;
  localparam int FTBS_NARROW_ADDR_W = 22;
  localparam int FTBS_LANE_W = 9;
  localparam int FTBS_SEED_W = 2;
  localparam int FTBS_BUF_DEPTH = 2;

  localparam logic [FTBS_SEED_W-1:0] FTBS_CNT_RST = 2'h0;
  localparam logic [FTBS_SEED_W-1:0] FTBS_CNT_STEP = 2'h1;
  localparam logic [1:0] FTBS_BUF_CNT_RST = 2'h0;
  localparam logic [1:0] FTBS_BUF_FULL = 2'h2;

  typedef enum logic [1:0]
  {
    FTBS_IDLE = 2'b00,
    FTBS_READ = 2'b01,
    FTBS_WRITE = 2'b10
  } ftbs_op_t;

  // Low burst address bits for the given seed and step count.
  function automatic logic [FTBS_SEED_W-1:0] ftbs_burst_low(
    input logic [FTBS_SEED_W-1:0] seed,
    input logic [FTBS_SEED_W-1:0] cnt,
    input logic interleaved
  );
    if (interleaved)
    begin
      return seed ^ cnt;
    end
    return seed + cnt;
  endfunction

  // Replaces the lanes whose active-low select is low; used by array and overlay.
  function automatic logic [FTBS_WIDE_DATA_W-1:0] ftbs_lane_merge(
    input logic [FTBS_WIDE_DATA_W-1:0] old_word,
    input logic [FTBS_WIDE_DATA_W-1:0] new_word,
    input logic [FTBS_WIDE_DATA_W/FTBS_LANE_W-1:0] lanes_n
  );
    logic [FTBS_WIDE_DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < FTBS_WIDE_DATA_W / FTBS_LANE_W; i++)
    begin
      if (!lanes_n[i])
      begin
        res[i*FTBS_LANE_W +: FTBS_LANE_W] = new_word[i*FTBS_LANE_W +: FTBS_LANE_W];
      end
    end
    return res;
  endfunction

endpackage

// ==== rtl/ftbs_mem_if.sv ====
/*
  Carrier between the port logic and its storage array.
  Assumes both ends run on the same clock.
*/
interface ftbs_mem_if #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 21
);
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_valid;
  logic wr_ready;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W/9-1:0] wr_lanes_n;
  logic sleep;

  modport port
  (
    output rd_en, rd_addr, wr_valid, wr_addr, wr_data, wr_lanes_n, sleep,
    input rd_data, wr_ready
  );
  modport array
  (
    input rd_en, rd_addr, wr_valid, wr_addr, wr_data, wr_lanes_n, sleep,
    output rd_data, wr_ready
  );
endinterface

// ==== rtl/ftbs_mem.sv ====
/*
  Storage array with registered read data and write-first behaviour on a clash.
  Assumes the port logic merges any still-buffered write data into its output.
*/
module ftbs_mem #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 21
) (
  input wire logic sys_clk,
  ftbs_mem_if.array mem
);
  import ftbs_pkg::*;

  logic [DATA_W-1:0] store [2**ADDR_W];
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;
  logic [DATA_W-1:0] wr_word;
  logic do_write;

  // Writes stall while asleep; the port buffer absorbs the pending word.
  assign mem.wr_ready = !mem.sleep;
  assign do_write = mem.wr_valid && mem.wr_ready;
  assign mem.rd_data = rd_data;

  always_comb
  begin
    wr_word = DATA_W'(ftbs_lane_merge(FTBS_WIDE_DATA_W'(store[mem.wr_addr]),
      FTBS_WIDE_DATA_W'(mem.wr_data), (FTBS_WIDE_DATA_W/FTBS_LANE_W)'(mem.wr_lanes_n)));
    next_rd_data = rd_data;
    if (mem.rd_en)
    begin
      next_rd_data = (do_write && mem.wr_addr == mem.rd_addr) ? wr_word : store[mem.rd_addr];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rd_data <= next_rd_data;
    if (do_write)
    begin
      store[mem.wr_addr] <= wr_word;
    end
  end
endmodule

// ==== rtl/ftbs_port.sv ====
/*
  Flow-through burst SRAM port: input registers, burst counter, late-write buffer,
  output drive control and storage array.
  Assumes pins are synchronous to sys_clk and the testbench resolves the data wire.
*/
module ftbs_port #(
  parameter int DATA_W = ftbs_pkg::FTBS_WIDE_DATA_W,
  parameter int ADDR_W = ftbs_pkg::FTBS_WIDE_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_qualify_n,
  input wire logic [ADDR_W-ftbs_pkg::FTBS_SEED_W-1:0] address_high,
  input wire logic [ftbs_pkg::FTBS_SEED_W-1:0] burst_seed_bits,
  input wire logic step_or_reload,
  input wire logic write_strobe_n,
  input wire logic [DATA_W/ftbs_pkg::FTBS_LANE_W-1:0] byte_lane_write_n,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two,
  input wire logic chip_select_three_n,
  input wire logic output_enable_n,
  input wire logic interleaved_order,
  input wire logic sleep_request,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] dq_oe,
  output logic low_power,
  output logic write_buffer_ready
);
  import ftbs_pkg::*;

  localparam int LANES = DATA_W / FTBS_LANE_W;

  if (!((DATA_W == FTBS_WIDE_DATA_W && ADDR_W == FTBS_WIDE_ADDR_W) ||
        (DATA_W == FTBS_NARROW_DATA_W && ADDR_W == FTBS_NARROW_ADDR_W)))
  begin : g_bad_org
    $error("Unsupported organisation");
  end

  ftbs_mem_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) mem ();

  ftbs_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mem
  (
    .sys_clk(sys_clk),
    .mem(mem)
  );

  ftbs_op_t op, next_op;
  logic [ADDR_W-FTBS_SEED_W-1:0] base_hi, next_base_hi;
  logic [FTBS_SEED_W-1:0] seed, next_seed, cnt, next_cnt;
  logic drive, next_drive;
  logic wr_pend, next_wr_pend;
  logic [ADDR_W-1:0] wr_pend_addr, next_wr_pend_addr;
  logic [ADDR_W-1:0] buf_addr [FTBS_BUF_DEPTH];
  logic [ADDR_W-1:0] next_buf_addr [FTBS_BUF_DEPTH];
  logic [DATA_W-1:0] buf_data [FTBS_BUF_DEPTH];
  logic [DATA_W-1:0] next_buf_data [FTBS_BUF_DEPTH];
  logic [LANES-1:0] buf_lanes [FTBS_BUF_DEPTH];
  logic [LANES-1:0] next_buf_lanes [FTBS_BUF_DEPTH];
  logic [1:0] buf_cnt, next_buf_cnt, idx;
  logic [DATA_W-1:0] ovl_data, next_ovl_data;
  logic [LANES-1:0] ovl_lanes_n, next_ovl_lanes_n;
  logic qual, sel, push, pop;
  logic [ADDR_W-1:0] acc_addr;

  assign qual = !clock_qualify_n;
  assign sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
  assign push = qual && wr_pend;
  assign pop = qual && buf_cnt != FTBS_BUF_CNT_RST && mem.wr_ready;
  assign write_buffer_ready = buf_cnt != FTBS_BUF_FULL || mem.wr_ready;

  // Buffered writes may still be in flight, so reads overlay them on the array word.
  assign dq_out = DATA_W'(ftbs_lane_merge(FTBS_WIDE_DATA_W'(mem.rd_data),
    FTBS_WIDE_DATA_W'(ovl_data), (FTBS_WIDE_DATA_W/FTBS_LANE_W)'(ovl_lanes_n)));
  assign dq_oe = {DATA_W{drive && !output_enable_n}};
  assign low_power = sleep_request || (op == FTBS_IDLE && !wr_pend && buf_cnt == FTBS_BUF_CNT_RST);

  assign mem.wr_valid = qual && buf_cnt != FTBS_BUF_CNT_RST;
  assign mem.wr_addr = buf_addr[0];
  assign mem.wr_data = buf_data[0];
  assign mem.wr_lanes_n = buf_lanes[0];
  assign mem.sleep = sleep_request;
  assign mem.rd_addr = acc_addr;

  always_comb
  begin
    next_op = op;
    next_base_hi = base_hi;
    next_seed = seed;
    next_cnt = cnt;
    next_drive = drive;
    next_wr_pend = wr_pend;
    next_wr_pend_addr = wr_pend_addr;
    next_ovl_data = ovl_data;
    next_ovl_lanes_n = ovl_lanes_n;
    mem.rd_en = 1'b0;
    if (qual)
    begin
      if (sleep_request)
      begin
        next_op = FTBS_IDLE;
      end
      else if (!step_or_reload)
      begin
        next_op = !sel ? FTBS_IDLE : (write_strobe_n ? FTBS_READ : FTBS_WRITE);
        next_base_hi = address_high;
        next_seed = burst_seed_bits;
        next_cnt = FTBS_CNT_RST;
      end
      else if (op != FTBS_IDLE)
      begin
        next_cnt = cnt + FTBS_CNT_STEP;
      end
    end
    acc_addr = {next_base_hi, ftbs_burst_low(next_seed, next_cnt, interleaved_order)};
    if (qual)
    begin
      next_drive = 1'b0;
      next_wr_pend = 1'b0;
      unique case (next_op)
        FTBS_READ:
        begin
          mem.rd_en = 1'b1;
          next_drive = 1'b1;
          next_ovl_lanes_n = '1;
          for (int i = 0; i < FTBS_BUF_DEPTH; i++)
          begin
            if (2'(i) < buf_cnt && buf_addr[i] == acc_addr)
            begin
              next_ovl_data = DATA_W'(ftbs_lane_merge(FTBS_WIDE_DATA_W'(next_ovl_data),
                FTBS_WIDE_DATA_W'(buf_data[i]), (FTBS_WIDE_DATA_W/FTBS_LANE_W)'(buf_lanes[i])));
              next_ovl_lanes_n = next_ovl_lanes_n & buf_lanes[i];
            end
          end
          if (wr_pend && wr_pend_addr == acc_addr)
          begin
            next_ovl_data = DATA_W'(ftbs_lane_merge(FTBS_WIDE_DATA_W'(next_ovl_data),
              FTBS_WIDE_DATA_W'(dq_in), (FTBS_WIDE_DATA_W/FTBS_LANE_W)'(byte_lane_write_n)));
            next_ovl_lanes_n = next_ovl_lanes_n & byte_lane_write_n;
          end
        end
        FTBS_WRITE:
        begin
          next_wr_pend = 1'b1;
          next_wr_pend_addr = acc_addr;
        end
        FTBS_IDLE:
        begin
          next_wr_pend = 1'b0;
        end
        default:
        begin
          next_wr_pend = 1'b0;
        end
      endcase
    end
  end

  // Late-write buffer: data and lanes of a write arrive one edge after its address.
  always_comb
  begin
    next_buf_addr = buf_addr;
    next_buf_data = buf_data;
    next_buf_lanes = buf_lanes;
    next_buf_cnt = buf_cnt;
    idx = buf_cnt;
    if (pop)
    begin
      next_buf_addr[0] = buf_addr[1];
      next_buf_data[0] = buf_data[1];
      next_buf_lanes[0] = buf_lanes[1];
      idx = buf_cnt - 2'h1;
    end
    if (push && idx != FTBS_BUF_FULL)
    begin
      next_buf_addr[idx[0]] = wr_pend_addr;
      next_buf_data[idx[0]] = dq_in;
      next_buf_lanes[idx[0]] = byte_lane_write_n;
      idx = idx + 2'h1;
    end
    next_buf_cnt = idx;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      op <= FTBS_IDLE;
      base_hi <= '0;
      seed <= FTBS_CNT_RST;
      cnt <= FTBS_CNT_RST;
      drive <= 1'b0;
      wr_pend <= 1'b0;
      wr_pend_addr <= '0;
      ovl_data <= '0;
      ovl_lanes_n <= '1;
      buf_cnt <= FTBS_BUF_CNT_RST;
    end
    else
    begin
      op <= next_op;
      base_hi <= next_base_hi;
      seed <= next_seed;
      cnt <= next_cnt;
      drive <= next_drive;
      wr_pend <= next_wr_pend;
      wr_pend_addr <= next_wr_pend_addr;
      ovl_data <= next_ovl_data;
      ovl_lanes_n <= next_ovl_lanes_n;
      buf_cnt <= next_buf_cnt;
    end
    buf_addr <= next_buf_addr;
    buf_data <= next_buf_data;
    buf_lanes <= next_buf_lanes;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_read_drives;
    qual && !sleep_request && !step_or_reload && sel && write_strobe_n |=> drive ##0 dq_oe == {DATA_W{!output_enable_n}};
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("Read did not drive data");

  property p_write_quiet;
    qual && !sleep_request && !step_or_reload && sel && !write_strobe_n |=> !drive && dq_oe == '0;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("Drivers on during write data");

  property p_hold;
    !qual |=> $stable(dq_out) && $stable(drive) && $stable(cnt) && $stable(op);
  endproperty
  a_hold: assert property (p_hold) else $error("State moved without qualified clock");

  property p_capture;
    qual && !sleep_request && !step_or_reload |=> base_hi == $past(address_high) && seed == $past(burst_seed_bits);
  endproperty
  a_capture: assert property (p_capture) else $error("Address not captured");

  property p_write_lands;
    qual && wr_pend && buf_cnt == FTBS_BUF_CNT_RST |=> buf_cnt == 2'h1 && buf_lanes[0] == $past(byte_lane_write_n);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("Write data not taken");

  property p_advance;
    qual && !sleep_request && step_or_reload && op != FTBS_IDLE |=> cnt == $past(cnt) + FTBS_CNT_STEP;
  endproperty
  a_advance: assert property (p_advance) else $error("Burst counter did not step");

  property p_load_clears;
    qual && !sleep_request && !step_or_reload |=> cnt == FTBS_CNT_RST;
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("Load did not clear counter");

  property p_deselect;
    qual && !step_or_reload && !sel |=> op == FTBS_IDLE ##1 (!$past(step_or_reload) || op == FTBS_IDLE);
  endproperty
  a_deselect: assert property (p_deselect) else $error("Deselected access started");

  property p_oe_async;
    output_enable_n |-> dq_oe == '0;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("Driving with output enable high");

  property p_sleep_power;
    sleep_request |-> low_power;
  endproperty
  a_sleep_power: assert property (p_sleep_power) else $error("Sleep without low power");

  property p_turnaround;
    qual && wr_pend && !sleep_request && !step_or_reload && sel && write_strobe_n |=> drive && buf_cnt != FTBS_BUF_CNT_RST;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("Write-to-read turnaround stalled");

  c_read: cover property (qual && op == FTBS_READ ##1 qual && op == FTBS_READ);
  c_write_read: cover property (op == FTBS_WRITE ##1 op == FTBS_READ);
  c_burst: cover property (qual && step_or_reload && op == FTBS_READ ##1 cnt == 2'h3);
  c_hold: cover property (drive && !qual ##1 !qual);
endmodule

// ==== testbench/ftbs_ctrl.sv ====
/*
  Memory controller model that drives the pins of the flow-through burst SRAM port.
  Assumes the bench calls its tasks once per cycle and resolves the data wire itself.
*/
module ftbs_ctrl (
  input wire logic sys_clk,
  output logic clock_qualify_n,
  output logic [18:0] address_high,
  output logic [1:0] burst_seed_bits,
  output logic step_or_reload,
  output logic write_strobe_n,
  output logic [3:0] byte_lane_write_n,
  output logic chip_select_one_n,
  output logic chip_select_two,
  output logic chip_select_three_n,
  output logic [35:0] wdata,
  output logic wdrive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pend = 1'b0;
  logic [35:0] pend_data;
  logic [3:0] pend_lanes;
  initial
  begin
    clock_qualify_n = 1'b0;
    {address_high, burst_seed_bits} = 21'h00_0000;
    step_or_reload = 1'b0;
    write_strobe_n = 1'b1;
    byte_lane_write_n = 4'hf;
    {chip_select_one_n, chip_select_two, chip_select_three_n} = 3'b101;
    wdata = 36'h0_0000_0000;
    wdrive = 1'b0;
  end
  // One qualified cycle: a new command plus the data of the write issued one cycle earlier.
  // Called just after a rising edge; returns just after the edge that takes the pins.
  task automatic issue(input logic wr, input logic adv, input logic [2:0] cs, input logic [20:0] a,
    input logic [3:0] ln, input logic [35:0] d);
    clock_qualify_n = 1'b0;
    step_or_reload = adv;
    write_strobe_n = !wr;
    {chip_select_one_n, chip_select_two, chip_select_three_n} = cs;
    {address_high, burst_seed_bits} = a;
    wdrive = pend;
    // An undriven wire flips every cycle, so stale data can never look valid.
    wdata = pend ? pend_data : ~wdata;
    byte_lane_write_n = pend ? pend_lanes : 4'hf;
    pend = wr;
    pend_data = d;
    pend_lanes = ln;
    @(posedge sys_clk);
    #2;
  endtask
  // Stalls the next edge and scrambles the address so a leaked edge would show.
  task automatic hold;
    clock_qualify_n = 1'b1;
    address_high = ~address_high;
    @(posedge sys_clk);
    #2;
  endtask
endmodule

// ==== testbench/tb.sv ====
/*
  Self-checking bench of the flow-through burst SRAM port in its wide organisation.
  Assumes the controller model ftbs_ctrl and a 40 MHz clock made here.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ftbs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic output_enable_n = 1'b0;
  logic interleaved_order = 1'b0;
  logic sleep_request = 1'b0;
  logic clock_qualify_n;
  logic [18:0] address_high;
  logic [1:0] burst_seed_bits;
  logic step_or_reload;
  logic write_strobe_n;
  logic [3:0] byte_lane_write_n;
  logic chip_select_one_n;
  logic chip_select_two;
  logic chip_select_three_n;
  logic [35:0] wdata;
  logic wdrive;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic [35:0] dq_oe;
  logic low_power;
  logic write_buffer_ready;
  int failures = 0;
  int samples_checked = 0;
  logic [35:0] ref_mem [int];
  logic [20:0] base = 21'h00_0000;
  logic [1:0] cnt = 2'h0;
  logic pw = 1'b0;
  logic [20:0] pa;
  logic [35:0] pd;
  logic [3:0] pl;
  logic [35:0] salt = 36'h0_0000_0000;
  logic [20:0] tbl [4] = '{21'h00_0000, 21'h15_5554, 21'h0a_aaa8, 21'h1f_fffc};

  always #12.5 sys_clk = ~sys_clk;
  assign dq_in = wdrive ? wdata : (dq_oe & dq_out) | (~dq_oe & wdata);

  ftbs_ctrl i_ctrl (.sys_clk(sys_clk), .clock_qualify_n(clock_qualify_n), .address_high(address_high),
    .burst_seed_bits(burst_seed_bits), .step_or_reload(step_or_reload), .write_strobe_n(write_strobe_n),
    .byte_lane_write_n(byte_lane_write_n), .chip_select_one_n(chip_select_one_n),
    .chip_select_two(chip_select_two), .chip_select_three_n(chip_select_three_n), .wdata(wdata), .wdrive(wdrive));
  ftbs_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clock_qualify_n(clock_qualify_n),
    .address_high(address_high), .burst_seed_bits(burst_seed_bits), .step_or_reload(step_or_reload),
    .write_strobe_n(write_strobe_n), .byte_lane_write_n(byte_lane_write_n),
    .chip_select_one_n(chip_select_one_n), .chip_select_two(chip_select_two),
    .chip_select_three_n(chip_select_three_n), .output_enable_n(output_enable_n),
    .interleaved_order(interleaved_order), .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .low_power(low_power), .write_buffer_ready(write_buffer_ready));

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One selected access; the reference takes the previous write's data first, as the port does.
  task automatic op(input logic wr, input logic adv, input logic [20:0] a, input logic [3:0] ln);
    logic [20:0] ea;
    logic [35:0] m;
    if (!adv)
    begin
      base = a;
      cnt = 2'h0;
    end
    else
    begin
      cnt = cnt + 2'h1;
    end
    ea = {base[20:2], interleaved_order ? base[1:0] ^ cnt : base[1:0] + cnt};
    i_ctrl.issue(wr, adv, 3'b010, a, ln, {ea, ea[14:0]} ^ salt);
    if (pw)
    begin
      m = ref_mem.exists(pa) ? ref_mem[pa] : 'x;
      for (int i = 0; i < 4; i++)
      begin
        if (!pl[i])
        begin
          m[i*9 +: 9] = pd[i*9 +: 9];
        end
      end
      ref_mem[pa] = m;
    end
    pw = wr;
    pa = ea;
    pd = {ea, ea[14:0]} ^ salt;
    pl = ln;
    if (wr)
    begin
      cmp(dq_oe, 36'h0_0000_0000);
    end
    else
    begin
      cmp(dq_out, ref_mem[ea]);
      cmp(dq_oe, 36'hf_ffff_ffff);
    end
    cmp({35'h0, write_buffer_ready}, 36'h1);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    cmp({33'h0, low_power, write_buffer_ready, dq_oe[0]}, 36'h6);
    @(posedge sys_clk);
    #2;
    for (int i = 0; i < 4; i++)
    begin
      op(1'b1, 1'b0, tbl[i], 4'h0);
      op(1'b0, 1'b0, tbl[i], 4'hf);
    end
    salt = 36'hf_0f0f_0f0f;
    op(1'b1, 1'b0, tbl[0], 4'h5);
    op(1'b0, 1'b0, tbl[0], 4'hf);
    for (int i = 1; i < 4; i++)
    begin
      op(1'b0, 1'b0, tbl[i], 4'hf);
    end
    for (int m = 0; m < 2; m++)
    begin
      interleaved_order = m[0];
      op(1'b1, 1'b0, 21'h00_0106 + 21'(m), 4'h0);
      repeat (3) op(1'b1, 1'b1, 21'h00_0000, 4'h0);
      op(1'b0, 1'b0, 21'h00_0105 + 21'(m), 4'hf);
      repeat (3) op(1'b0, 1'b1, 21'h00_0000, 4'hf);
    end
    op(1'b0, 1'b0, tbl[2], 4'hf);
    i_ctrl.hold();
    cmp(dq_out, ref_mem[tbl[2]]);
    cmp(dq_oe, 36'hf_ffff_ffff);
    op(1'b0, 1'b0, tbl[3], 4'hf);
    // The standing read is taken once more at the next edge, which is harmless.
    output_enable_n = 1'b1;
    #1;
    cmp(dq_oe, 36'h0_0000_0000);
    output_enable_n = 1'b0;
    #1;
    cmp(dq_oe, 36'hf_ffff_ffff);
    @(posedge sys_clk);
    #2;
    op(1'b0, 1'b0, tbl[1], 4'hf);
    op(1'b1, 1'b0, tbl[1], 4'h3);
    op(1'b1, 1'b0, tbl[2], 4'hc);
    // Sleep stalls the array, so the last write data fills the second buffer entry.
    sleep_request = 1'b1;
    i_ctrl.issue(1'b0, 1'b0, 3'b000, tbl[0], 4'hf, 36'h0_0000_0000);
    cmp({34'h0, low_power, write_buffer_ready}, 36'h2);
    cmp(dq_oe, 36'h0_0000_0000);
    sleep_request = 1'b0;
    op(1'b0, 1'b0, tbl[2], 4'hf);
    op(1'b0, 1'b0, tbl[1], 4'hf);
    foreach (tbl[i])
    begin
      if (i < 3)
      begin
        i_ctrl.issue(1'b0, 1'b0, i == 0 ? 3'b110 : i == 1 ? 3'b000 : 3'b011, tbl[0], 4'hf, '0);
        cmp(dq_oe, 36'h0_0000_0000);
        cmp({35'h0, low_power}, 36'h1);
      end
    end
    report_and_stop();
  end

  // The sequence needs well under 100 cycles; this bound only catches a hang.
  initial
  begin
    #10us;
    failures++;
    report_and_stop();
  end
endmodule
